// File: src/servo_output_command_handler.sv
`timescale 1ns/10ps
`include "servo_cmd_defs.svh"


module servo_output_command_handler (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire servo_cmd_pkg::host_wr_t host_wr_i,
   input wire servo_cmd_pkg::host_rd_t host_rd_i,
   output logic [7:0] host_rdata_o,
   output logic host_irq_o,
   input wire servo_cmd_pkg::axis_in_t [`AXES-1:0] axis_i,
   output servo_cmd_pkg::axis_out_t [`AXES-1:0] axis_o
);

   servo_cmd_pkg::ctl_t s_r;
   servo_cmd_pkg::ctl_t s_nxt;

   logic [`AXES-1:0][`DRIVE_W-1:0] raw_w;
   logic [`AXES-1:0][`DRIVE_W-1:0] drv_w;
   logic [`AXES-1:0][`RELAYS-1:0] rly_w;
   logic [`AXES-1:0][`DRIVE_W-1:0] offset_w;
   logic [`AXES-1:0] pos_zero_w;
   logic tune_done_w;
   logic [1:0] tune_axis_w;
   logic [`ADDR_W-1:0] wr_off;
   logic [`ADDR_W-1:0] rd_off;
   logic wr_in_cmd;
   logic rd_in_cmd;
   logic [7:0] sel_byte;
   logic [7:0] arg_byte;
   logic sel_onehot;
   logic [1:0] sel_axis;

   // ---------------------------------------------------------
   // Per-axis output path
   // ---------------------------------------------------------
   genvar k;
   generate
      for (k = 0; k < `AXES; k++) begin : g_axis
         // Shift of a sign-extended word; 4 spare bits hold x16
         assign raw_w[k] = {{(`DRIVE_W - `LOOP_W){axis_i[k].loop_out[
            `LOOP_W-1]}}, axis_i[k].loop_out} << s_r.gain[k];
         assign drv_w[k] = raw_w[k] - offset_w[k];
         // Axis 4 lines double as the general-purpose outputs
         assign rly_w[k] = ~(axis_i[k].relay_req ^ s_r.pol[k]);
         assign pos_zero_w[k] = axis_i[k].pos_zero;
         assign axis_o[k].drive = s_r.drv[k];
         assign axis_o[k].relay = s_r.rly[k];
         assign axis_o[k].gain = s_r.gain[k];
      end
   endgenerate

   // ---------------------------------------------------------
   // Offset tuning engine
   // ---------------------------------------------------------
   offset_tuner u_tuner (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .start_i(s_r.tune_start),
      .axis_sel_i(s_r.axis),
      .pos_zero_i(pos_zero_w),
      .raw_i(raw_w),
      .offset_o(offset_w),
      .done_o(tune_done_w),
      .done_axis_o(tune_axis_w)
   );

   // ---------------------------------------------------------
   // Decode helpers
   // ---------------------------------------------------------
   assign wr_off = host_wr_i.addr - `CMD_CODE_ADDR;
   assign rd_off = host_rd_i.addr - `CMD_CODE_ADDR;
   assign wr_in_cmd = wr_off < `ADDR_W'(`CMD_BYTES);
   assign rd_in_cmd = rd_off < `ADDR_W'(`CMD_BYTES);
   assign sel_byte = s_r.cmd[1];
   assign arg_byte = s_r.cmd[s_r.ptr];
   assign sel_onehot = $onehot(sel_byte[`AXES-1:0])
      && sel_byte[7:`AXES] == 4'h0;

   // Bit k of the select byte names axis k+1
   always_comb begin
      sel_axis = 2'h0;
      if (sel_byte[1]) begin
         sel_axis = 2'h1;
      end
      if (sel_byte[2]) begin
         sel_axis = 2'h2;
      end
      if (sel_byte[3]) begin
         sel_axis = 2'h3;
      end
   end

   // ---------------------------------------------------------
   // Command sequencer and shared locations
   // ---------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.tune_start = 1'b0;
      s_nxt.drv = drv_w;
      s_nxt.rly = rly_w;

      unique case (s_r.st)
         servo_cmd_pkg::ST_IDLE: begin
            if (s_r.cmd[0] != `OP_NONE) begin
               s_nxt.st = servo_cmd_pkg::ST_DECODE;
            end
         end
         servo_cmd_pkg::ST_DECODE: begin
            s_nxt.axis = 2'h0;
            s_nxt.ptr = `CMD_PTR_ARG1;
            unique case (s_r.cmd[0])
               `OP_OFFSET: begin
                  // Several or no axis bits: refused, nothing tuned
                  if (sel_onehot) begin
                     s_nxt.axis = sel_axis;
                     s_nxt.tune_start = 1'b1;
                     s_nxt.st = servo_cmd_pkg::ST_TUNE;
                  end else begin
                     s_nxt.st = servo_cmd_pkg::ST_FINISH;
                  end
               end
               `OP_GAIN, `OP_RELAY: begin
                  s_nxt.st = servo_cmd_pkg::ST_APPLY;
               end
               default: begin
                  s_nxt.st = servo_cmd_pkg::ST_FINISH;
               end
            endcase
         end
         servo_cmd_pkg::ST_APPLY: begin
            // One axis per cycle; argument pointer moves only on hits
            if (sel_byte[s_r.axis]) begin
               if (s_r.cmd[0] == `OP_GAIN) begin
                  // Codes above 4 are dropped, old gain stays
                  if (arg_byte <= `GAIN_CODE_MAX) begin
                     s_nxt.gain[s_r.axis] = arg_byte[2:0];
                  end
               end else begin
                  s_nxt.pol[s_r.axis] = arg_byte[2:0];
               end
               s_nxt.ptr = s_r.ptr + 3'h1;
            end
            if (s_r.axis == `AXIS_LAST) begin
               s_nxt.st = servo_cmd_pkg::ST_FINISH;
            end else begin
               s_nxt.axis = s_r.axis + 2'h1;
            end
         end
         servo_cmd_pkg::ST_TUNE: begin
            if (tune_done_w) begin
               s_nxt.st = servo_cmd_pkg::ST_FINISH;
            end
         end
         servo_cmd_pkg::ST_FINISH: begin
            s_nxt.cmd[0] = `OP_NONE;
            s_nxt.st = servo_cmd_pkg::ST_IDLE;
         end
         default: begin
            s_nxt.st = servo_cmd_pkg::ST_IDLE;
         end
      endcase

      // Host read port and read-to-clear status
      s_nxt.rdata = 8'h00;
      if (host_rd_i.re) begin
         if (rd_in_cmd) begin
            s_nxt.rdata = s_r.cmd[rd_off[2:0]];
         end
         unique case (host_rd_i.addr)
            `IRQ_CAUSE_ADDR: begin
               s_nxt.rdata = s_r.cause;
               s_nxt.cause = 8'h00;
               s_nxt.irq = 1'b0;
            end
            `IRQ_AXIS_ADDR: begin
               s_nxt.rdata = s_r.src;
            end
            `EVT_LOW_ADDR: begin
               s_nxt.rdata = s_r.evt_lo;
               s_nxt.evt_lo = 8'h00;
            end
            `EVT_HIGH_ADDR: begin
               s_nxt.rdata = s_r.evt_hi;
               s_nxt.evt_hi = 8'h00;
            end
            default: begin
            end
         endcase
      end

      // Host write after the sequencer, so a new code beats the clear
      if (host_wr_i.we && wr_in_cmd) begin
         s_nxt.cmd[wr_off[2:0]] = host_wr_i.data;
      end

      // Completion last: a set in the clearing cycle wins
      if (tune_done_w) begin
         s_nxt.cause[`CAUSE_OFFSET_BIT] = 1'b1;
         s_nxt.irq = 1'b1;
         s_nxt.src = 8'h01 << tune_axis_w;
         s_nxt.evt_lo[`EVT_OFFSET_BIT] = 1'b1;
         s_nxt.evt_hi[`EVT_OFFSET_BIT] = 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
         s_r.gain <= {`AXES{`GAIN_RESET}};
         s_r.pol <= {`AXES{`POL_RESET}};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign host_rdata_o = s_r.rdata;
   assign host_irq_o = s_r.irq;

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_irq_on_done: assert property (
      tune_done_w |=> host_irq_o && s_r.cause[`CAUSE_OFFSET_BIT])
      else $error("no interrupt after offset completion");

   a_axis_source: assert property (
      tune_done_w |=> s_r.src == (8'h01 << $past(tune_axis_w)))
      else $error("wrong axis identity after offset");

   a_event_bits: assert property (
      tune_done_w |=> s_r.evt_lo[`EVT_OFFSET_BIT]
         && s_r.evt_hi[`EVT_OFFSET_BIT])
      else $error("event bit 6 not set after offset");

   a_offset_refuse: assert property (
      s_r.st == servo_cmd_pkg::ST_DECODE && s_r.cmd[0] == `OP_OFFSET
         && !sel_onehot |=> s_r.st == servo_cmd_pkg::ST_FINISH
         && !$past(s_nxt.tune_start))
      else $error("offset started without a single axis");

   a_relay_done: assert property (
      s_r.st == servo_cmd_pkg::ST_DECODE && s_r.cmd[0] == `OP_RELAY
         |-> ##[5:5] s_r.st == servo_cmd_pkg::ST_FINISH)
      else $error("relay command did not complete in time");

   a_gain_keep: assert property (
      $changed(s_r.gain) |-> $past(s_r.st) == servo_cmd_pkg::ST_APPLY
         && $past(sel_byte[s_r.axis]))
      else $error("gain changed outside a selected axis slot");

   a_gain_range: assert property (
      $changed(s_r.gain[0]) |-> s_r.gain[0] <= 3'h4)
      else $error("gain code above 4 was stored");

   a_gain_x16: assert property (
      s_r.gain[0] == 3'h4 && offset_w[0] == '0 && $stable(s_r.gain[0])
         |=> axis_o[0].drive == `DRIVE_W'($signed($past(
            axis_i[0].loop_out)) * 16))
      else $error("gain code 4 does not scale by 16");

   a_relay_level: assert property (
      s_r.pol[3][0] && $stable(s_r.pol[3]) && axis_i[3].relay_req[0]
         |=> axis_o[3].relay[0])
      else $error("active-high output line not driven high");

   a_cmd_cleared: assert property (
      s_r.st == servo_cmd_pkg::ST_FINISH && !(host_wr_i.we
         && host_wr_i.addr == `CMD_CODE_ADDR) |=> s_r.cmd[0] == `OP_NONE)
      else $error("command code not cleared at finish");

endmodule

// File: src/servo_cmd_defs.svh
`ifndef SERVO_CMD_DEFS_SVH
`define SERVO_CMD_DEFS_SVH

// ------------------------------------------------------------
// Shared host memory map
// ------------------------------------------------------------
`define ADDR_W 11
`define CMD_CODE_ADDR 11'h3c2
`define CMD_ARG0_ADDR 11'h3c3
`define CMD_BYTES 6
`define CMD_PTR_ARG1 3'h2
`define IRQ_CAUSE_ADDR 11'h009
`define IRQ_AXIS_ADDR 11'h00c
`define EVT_LOW_ADDR 11'h3fe
`define EVT_HIGH_ADDR 11'h7fe

// ------------------------------------------------------------
// Command codes and fields
// ------------------------------------------------------------
`define OP_NONE 8'h00
`define OP_OFFSET 8'h5f
`define OP_GAIN 8'h81
`define OP_RELAY 8'h59
`define EVT_OFFSET_BIT 6
`define CAUSE_OFFSET_BIT 6
`define AXIS_LAST 2'h3
`define GAIN_CODE_MAX 8'h04
`define GAIN_RESET 3'h0
`define POL_RESET 3'h7

// ------------------------------------------------------------
// Widths and timing
// ------------------------------------------------------------
`define AXES 4
`define LOOP_W 16
`define DRIVE_W 20
`define RELAYS 3
`define CLK_PERIOD_NS 10
`define TUNE_SETTLE_NS 10000
`define TUNE_SETTLE_CYC \
   ((`TUNE_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: src/servo_cmd_pkg.sv
`include "servo_cmd_defs.svh"

package servo_cmd_pkg;

   // ---------------------------------------------------------
   // Command sequencer states
   // ---------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE   = 3'b000,
      ST_DECODE = 3'b001,
      ST_APPLY  = 3'b010,
      ST_TUNE   = 3'b011,
      ST_FINISH = 3'b100
   } cmd_state_t;

   // ---------------------------------------------------------
   // Port carriers
   // ---------------------------------------------------------
   typedef struct packed {
      logic we;
      logic [`ADDR_W-1:0] addr;
      logic [7:0] data;
   } host_wr_t;

   typedef struct packed {
      logic re;
      logic [`ADDR_W-1:0] addr;
   } host_rd_t;

   typedef struct packed {
      logic [`LOOP_W-1:0] loop_out;
      logic pos_zero;
      logic [`RELAYS-1:0] relay_req;
   } axis_in_t;

   typedef struct packed {
      logic [`DRIVE_W-1:0] drive;
      logic [`RELAYS-1:0] relay;
      logic [2:0] gain;
   } axis_out_t;

   // ---------------------------------------------------------
   // Module state
   // ---------------------------------------------------------
   typedef struct packed {
      cmd_state_t st;
      logic [`CMD_BYTES-1:0][7:0] cmd;
      logic [2:0] ptr;
      logic [1:0] axis;
      logic [`AXES-1:0][2:0] gain;
      logic [`AXES-1:0][`RELAYS-1:0] pol;
      logic [`AXES-1:0][`DRIVE_W-1:0] drv;
      logic [`AXES-1:0][`RELAYS-1:0] rly;
      logic [7:0] cause;
      logic [7:0] src;
      logic [7:0] evt_lo;
      logic [7:0] evt_hi;
      logic [7:0] rdata;
      logic irq;
      logic tune_start;
   } ctl_t;

   typedef struct packed {
      logic busy;
      logic [1:0] axis;
      logic [11:0] cnt;
      logic [`AXES-1:0][`DRIVE_W-1:0] off;
      logic done;
      logic [1:0] done_axis;
   } tune_t;

endpackage

// File: src/offset_tuner.sv
`timescale 1ns/10ps
`include "servo_cmd_defs.svh"

module offset_tuner (
   input wire logic clk_i,
   input wire logic rstn_i,
   input wire logic start_i,
   input wire logic [1:0] axis_sel_i,
   input wire logic [`AXES-1:0] pos_zero_i,
   input wire logic [`AXES-1:0][`DRIVE_W-1:0] raw_i,
   output logic [`AXES-1:0][`DRIVE_W-1:0] offset_o,
   output logic done_o,
   output logic [1:0] done_axis_o
);

   servo_cmd_pkg::tune_t s_r;
   servo_cmd_pkg::tune_t s_nxt;
   logic [`DRIVE_W-1:0] sel_raw;

   assign sel_raw = raw_i[s_r.axis];

   // ---------------------------------------------------------
   // Settle and capture
   // ---------------------------------------------------------
   // Zero error must hold for the whole settle time; a glitch
   // restarts the count so a passing zero crossing is not taken.
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (!s_r.busy) begin
         if (start_i) begin
            s_nxt.busy = 1'b1;
            s_nxt.axis = axis_sel_i;
            s_nxt.cnt = '0;
         end
      end else if (!pos_zero_i[s_r.axis]) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt == 12'(`TUNE_SETTLE_CYC - 1)) begin
         s_nxt.off[s_r.axis] = sel_raw;
         s_nxt.busy = 1'b0;
         s_nxt.done = 1'b1;
         s_nxt.done_axis = s_r.axis;
      end else begin
         s_nxt.cnt = s_r.cnt + 12'h001;
      end
   end

   // Offsets are kept until rstn_i clears them or the same axis is tuned again
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign offset_o = s_r.off;
   assign done_o = s_r.done;
   assign done_axis_o = s_r.done_axis;

   // ---------------------------------------------------------
   // Checks
   // ---------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   a_capture_value: assert property (
      s_nxt.done |=> s_r.off[s_r.done_axis] == $past(sel_raw))
      else $error("captured offset differs from raw output");

   a_settle_time: assert property (
      s_r.done |-> $past(s_r.cnt) == 12'(`TUNE_SETTLE_CYC - 1))
      else $error("offset captured before settle time");

   genvar k;
   generate
      for (k = 0; k < `AXES; k++) begin : g_keep
         a_other_axes: assert property (
            $changed(s_r.off[k]) |-> $past(s_r.axis) == 2'(k))
            else $error("offset of an untuned axis changed");
      end
   endgenerate

endmodule

// File: verification/host_model.sv
`timescale 1ns/10ps
`include "servo_cmd_defs.svh"

module host_model (
   input wire logic clk_i,
   output servo_cmd_pkg::host_wr_t wr_o,
   output servo_cmd_pkg::host_rd_t rd_o,
   input wire logic [7:0] rdata_i
);
   // ---------------------------------------------------------
   // Shared memory byte access
   // ---------------------------------------------------------
   initial begin
      wr_o = '0;
      rd_o = '0;
   end

   // Strobe held across the sampling edge, then dropped
   task automatic wr(input logic [`ADDR_W-1:0] a, input logic [7:0] d);
      @(posedge clk_i);
      wr_o <= '{we: 1'b1, addr: a, data: d};
      @(posedge clk_i);
      wr_o.we <= 1'b0;
   endtask

   // Read data stands one cycle only, so it is taken at once
   task automatic rd(input logic [`ADDR_W-1:0] a, output logic [7:0] d);
      @(posedge clk_i);
      rd_o <= '{re: 1'b1, addr: a};
      @(posedge clk_i);
      rd_o.re <= 1'b0;
      #1;
      d = rdata_i;
   endtask

   // Code goes last so a half-written command is never parsed
   task automatic run_cmd(input logic [7:0] code, input logic [7:0] arg [5],
                          input int n);
      for (int i = 0; i < n; i++) begin
         wr(`CMD_ARG0_ADDR + 11'(i), arg[i]);
      end
      wr(`CMD_CODE_ADDR, code);
   endtask
endmodule

// File: verification/servo_output_command_handler_tb_top.sv
`timescale 1ns/10ps
`include "servo_cmd_defs.svh"

module servo_output_command_handler_tb_top;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   servo_cmd_pkg::host_wr_t host_wr;
   servo_cmd_pkg::host_rd_t host_rd;
   logic [7:0] rdata;
   logic irq;
   servo_cmd_pkg::axis_in_t [`AXES-1:0] axis_in = '0;
   servo_cmd_pkg::axis_out_t [`AXES-1:0] axis_out;
   int num_errors = 0;
   int num_checks = 0;
   logic [31:0] lfsr = 32'h0001_37e7;
   logic [2:0] gain_m [`AXES] = '{default: 3'h0};
   logic [2:0] pol_m [`AXES] = '{default: `POL_RESET};
   logic [15:0] off_m [`AXES] = '{default: 16'h0000};
   logic [7:0] args [5];
   logic [7:0] d;
   logic [7:0] sel;
   logic [15:0] x0;

   always #5 clk_i = ~clk_i;

   servo_output_command_handler uut (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .host_wr_i(host_wr),
      .host_rd_i(host_rd),
      .host_rdata_o(rdata),
      .host_irq_o(irq),
      .axis_i(axis_in),
      .axis_o(axis_out)
   );

   host_model host (
      .clk_i(clk_i),
      .wr_o(host_wr),
      .rd_o(host_rd),
      .rdata_i(rdata)
   );

   // ---------------------------------------------------------
   // Expectations and reporting
   // ---------------------------------------------------------
   function automatic logic [7:0] rnd();
      lfsr = lfsr[0] ? ((lfsr >> 1) ^ 32'ha300_0000) : (lfsr >> 1);
      return lfsr[7:0];
   endfunction

   function automatic logic [19:0] exp_drive(input logic [15:0] lo,
         input logic [2:0] g, input logic [15:0] off);
      logic [19:0] v;
      v = {{4{lo[15]}}, lo} << g;
      return v - {{4{off[15]}}, off};
   endfunction

   task automatic check(input logic [19:0] seen, input logic [19:0] exp,
                        input string what);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what,
                  seen, exp);
      end
   endtask

   task automatic complete_run;
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // Device clears the code byte when a command is done
   task automatic wait_idle;
      for (int i = 0; i < 100; i++) begin
         host.rd(`CMD_CODE_ADDR, d);
         if (d === 8'h00) begin
            return;
         end
      end
      check(20'(d), 20'h0_0000, "command never finished");
      complete_run;
   endtask

   // One argument byte per select bit, ascending axis order
   task automatic send(input logic [7:0] code, input logic [7:0] s);
      int n;
      logic [7:0] b;
      args[0] = s;
      n = 1;
      for (int k = 0; k < `AXES; k++) begin
         if (s[k]) begin
            b = rnd();
            if (code == `OP_GAIN) begin
               b = b % 8'h06;
               if (b <= `GAIN_CODE_MAX) begin
                  gain_m[k] = b[2:0];
               end
            end else begin
               pol_m[k] = b[2:0];
            end
            args[n] = b;
            n++;
         end
      end
      host.run_cmd(code, args, n);
      wait_idle();
   endtask

   // Fresh random inputs, then every axis output against the model
   task automatic check_outs;
      logic [7:0] r;
      logic [2:0] e;
      @(posedge clk_i);
      for (int k = 0; k < `AXES; k++) begin
         r = rnd();
         axis_in[k].relay_req <= r[2:0];
         axis_in[k].loop_out <= {rnd(), rnd()};
      end
      repeat (3) @(posedge clk_i);
      #1;
      for (int k = 0; k < `AXES; k++) begin
         // Inverted in 3 bits first, so the cast pads with zeros
         e = ~(axis_in[k].relay_req ^ pol_m[k]);
         check(20'(axis_out[k].gain), 20'(gain_m[k]), "gain");
         check(20'(axis_out[k].relay),
               20'(e), "relay");
         check(axis_out[k].drive,
               exp_drive(axis_in[k].loop_out, gain_m[k], off_m[k]), "drive");
      end
   endtask

   // ---------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------
   initial begin
      repeat (20) @(posedge clk_i);
      rstn_i <= 1'b1;
      @(posedge clk_i);
      #1;
      for (int k = 0; k < `AXES; k++) begin
         check(20'(axis_out[k].gain), 20'h0_0000, "reset gain");
      end
      check(20'(irq), 20'h0_0000, "reset irq");
      // Relay command straight after reset, no setup first
      send(`OP_RELAY, 8'h08);
      check_outs();
      repeat (6) begin
         sel = rnd() & 8'h0f;
         send(`OP_RELAY, (sel == 8'h00) ? 8'h0f : sel);
         check_outs();
      end
      repeat (8) begin
         sel = rnd() & 8'h0f;
         send(`OP_GAIN, (sel == 8'h00) ? 8'h0f : sel);
         check_outs();
      end
      // Unknown code is dropped and changes nothing
      host.run_cmd(8'h33, args, 0);
      wait_idle();
      check_outs();
      // Gain 16 on axis 1; unity on axis 3 keeps the captured value plain
      args[0] = 8'h05;
      args[1] = 8'h04;
      args[2] = 8'h00;
      host.run_cmd(`OP_GAIN, args, 3);
      wait_idle();
      gain_m[0] = 3'h4;
      gain_m[2] = 3'h0;
      check_outs();
      // Two axis bits, or only upper bits: no tuning, no interrupt
      host.run_cmd(`OP_OFFSET, args, 1);
      wait_idle();
      args[0] = 8'h10;
      host.run_cmd(`OP_OFFSET, args, 1);
      wait_idle();
      check(20'(irq), 20'h0_0000, "refused offset");
      args[0] = 8'h04;
      @(posedge clk_i);
      x0 = {rnd(), rnd()};
      axis_in[2].loop_out <= x0;
      axis_in[2].pos_zero <= 1'b1;
      host.run_cmd(`OP_OFFSET, args, 1);
      for (int i = 0; i < 1500 && irq !== 1'b1; i++) begin
         @(posedge clk_i);
         #1;
      end
      check(20'(irq), 20'h0_0001, "tuning irq");
      host.rd(`IRQ_CAUSE_ADDR, d);
      check(20'(d[`CAUSE_OFFSET_BIT]), 20'h0_0001, "cause");
      host.rd(`IRQ_AXIS_ADDR, d);
      check(20'(d), 20'h0_0004, "axis source");
      host.rd(`EVT_LOW_ADDR, d);
      check(20'(d[`EVT_OFFSET_BIT]), 20'h0_0001, "event low");
      host.rd(`EVT_HIGH_ADDR, d);
      check(20'(d[`EVT_OFFSET_BIT]), 20'h0_0001, "event high");
      check(20'(irq), 20'h0_0000, "irq after read");
      off_m[2] = x0;
      wait_idle();
      check_outs();
      complete_run();
   end
endmodule
